// ==== pkg/actr_consts.svh ====
// offsets, field positions, reset values and counts for the converter control block
`ifndef ACTR_CONSTS_SVH
`define ACTR_CONSTS_SVH
`define ACTR_OFS_RES_LOW   8'h78
`define ACTR_OFS_RES_HIGH  8'h79
`define ACTR_OFS_CTRL      8'h7a
`define ACTR_OFS_TRIG      8'h7b
`define ACTR_OFS_MUXCFG    8'h7c
`define ACTR_OFS_BUFOFF    8'h7e
`define ACTR_CTRL_ON       7
`define ACTR_CTRL_START    6
`define ACTR_CTRL_AUTO     5
`define ACTR_CTRL_DONE     4
`define ACTR_CTRL_IEN      3
`define ACTR_MUX_LEFT      5
`define ACTR_RST_BYTE      8'h00
`define ACTR_TRIG_MASK     8'h07
`define ACTR_BUF_MASK      8'h3f
`define ACTR_MUX_MASK      8'h2f
`define ACTR_CONV_CYCLES   13
`define ACTR_FIRST_CYCLES  25
`endif

// ==== pkg/actr_pkg.sv ====
// types for the converter control block
package actr_pkg;
  typedef enum logic [2:0] {
    ACTR_TRG_FREE,
    ACTR_TRG_ACOMP,
    ACTR_TRG_EXT0,
    ACTR_TRG_T0CMPA,
    ACTR_TRG_T0OVF,
    ACTR_TRG_T1CMPB,
    ACTR_TRG_T1OVF,
    ACTR_TRG_T1CAPT
  } actr_trig_t;
  typedef enum logic [1:0] {
    ACTR_IDLE,
    ACTR_CONV,
    ACTR_DONE
  } actr_state_t;
  // register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } actr_bus_t;
  // peripheral trigger flags, bit i is source code i+1
  typedef struct packed {
    logic t1_capt;
    logic t1_ovf;
    logic t1_cmpb;
    logic t0_ovf;
    logic t0_cmpa;
    logic ext0;
    logic acomp;
  } actr_flags_t;
endpackage

// ==== rtl/actr_top.sv ====
// converter clock, trigger, result and input buffer control
`timescale 1ns/1ns
`include "actr_consts.svh"
module actr_top #(
  parameter int RES_W = 10
) (
  input  wire logic                 CLK,
  input  wire logic                 NRST,
  input  wire actr_pkg::actr_bus_t  BUS,
  output logic [7:0]                RDATA,
  input  wire actr_pkg::actr_flags_t FLAGS,
  input  wire logic                 IRQ_ACK,
  input  wire logic [RES_W-1:0]     ANA_RESULT,
  input  wire logic [5:0]           PIN_IN,
  output logic [5:0]                PIN_SEEN,
  output logic [5:0]                PIN_BUF_OFF,
  output logic                      CONV_CLK_EN,
  output logic                      CONV_BUSY,
  output logic                      SAMPLE_REQ,
  output logic [3:0]                CHANNEL_SELECT,
  output logic                      DONE_IRQ
);
  import actr_pkg::*;

  if (RES_W != 10) begin : g_width_check
    $error("actr_top serves only a 10-bit result");
  end

  logic [7:0]        ctrl_q;
  logic [7:0]        trig_q;
  logic [7:0]        mux_q;
  logic [7:0]        buf_q;
  logic [RES_W-1:0]  result_q;
  logic              lock_q;
  logic              done_q;
  logic [6:0]        div_q;
  logic              first_q;
  logic [4:0]        cnt_q;
  actr_state_t       state_q;
  logic              trig_lvl_q;
  logic              start_pend_q;
  logic [5:0]        pin_s1_q;
  logic [5:0]        pin_s2_q;
  logic [5:0]        pin_s3_q;
  logic [5:0]        pin_stable_q;
  logic [7:0]        rd_low;
  logic [7:0]        rd_high;
  logic              trig_lvl_d;
  logic              trig_edge;
  logic              tick;
  logic              conv_end;
  logic [6:0]        div_mask;
  actr_trig_t        src;

  wire wr_ctrl  = BUS.wr && BUS.addr == `ACTR_OFS_CTRL;
  wire wr_trig  = BUS.wr && BUS.addr == `ACTR_OFS_TRIG;
  wire wr_mux   = BUS.wr && BUS.addr == `ACTR_OFS_MUXCFG;
  wire wr_buf   = BUS.wr && BUS.addr == `ACTR_OFS_BUFOFF;
  wire rd_lo    = BUS.rd && BUS.addr == `ACTR_OFS_RES_LOW;
  wire rd_hi    = BUS.rd && BUS.addr == `ACTR_OFS_RES_HIGH;
  wire conv_on  = ctrl_q[`ACTR_CTRL_ON];
  wire conv_on_d = wr_ctrl ? BUS.wdata[`ACTR_CTRL_ON] : conv_on;
  wire auto_on  = ctrl_q[`ACTR_CTRL_AUTO];
  wire left_on  = mux_q[`ACTR_MUX_LEFT];

  // prescaler: divide mask per code
  always_comb begin
    case (ctrl_q[2:0])
      3'h0, 3'h1: div_mask = 7'h01;
      3'h2:       div_mask = 7'h03;
      3'h3:       div_mask = 7'h07;
      3'h4:       div_mask = 7'h0f;
      3'h5:       div_mask = 7'h1f;
      3'h6:       div_mask = 7'h3f;
      default:    div_mask = 7'h7f;
    endcase
  end
  assign tick = (div_q & div_mask) == div_mask;

  always_ff @(posedge CLK) begin
    if (!NRST || !conv_on) begin
      div_q <= 7'h00;
    end else begin
      div_q <= div_q + 7'h01;
    end
  end

  // trigger source selection
  assign src = actr_trig_t'(trig_q[2:0]);
  always_comb begin
    case (src)
      ACTR_TRG_FREE:   trig_lvl_d = done_q;
      ACTR_TRG_ACOMP:  trig_lvl_d = FLAGS.acomp;
      ACTR_TRG_EXT0:   trig_lvl_d = FLAGS.ext0;
      ACTR_TRG_T0CMPA: trig_lvl_d = FLAGS.t0_cmpa;
      ACTR_TRG_T0OVF:  trig_lvl_d = FLAGS.t0_ovf;
      ACTR_TRG_T1CMPB: trig_lvl_d = FLAGS.t1_cmpb;
      ACTR_TRG_T1OVF:  trig_lvl_d = FLAGS.t1_ovf;
      default:         trig_lvl_d = FLAGS.t1_capt;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      trig_lvl_q <= 1'b0;
    end else if (wr_trig && BUS.wdata[2:0] == 3'h0) begin
      trig_lvl_q <= 1'b1;
    end else begin
      trig_lvl_q <= trig_lvl_d;
    end
  end
  // edge only, and only with auto triggering on
  assign trig_edge = auto_on && trig_lvl_d && !trig_lvl_q;

  // start request from software or trigger, served at next converter tick
  always_ff @(posedge CLK) begin
    if (!NRST || !conv_on_d) begin
      start_pend_q <= 1'b0;
    end else if (state_q != ACTR_CONV && (trig_edge || (wr_ctrl && BUS.wdata[`ACTR_CTRL_START]))) begin
      start_pend_q <= 1'b1;
    end else if (state_q == ACTR_CONV) begin
      start_pend_q <= 1'b0;
    end
  end

  // conversion sequencer
  assign conv_end = state_q == ACTR_CONV && tick && cnt_q == 5'h01;
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      state_q <= ACTR_IDLE;
      cnt_q   <= 5'h00;
      first_q <= 1'b1;
    end else if (!conv_on) begin
      state_q <= ACTR_IDLE;
      cnt_q   <= 5'h00;
      first_q <= 1'b1;
    end else begin
      case (state_q)
        ACTR_IDLE: begin
          if (start_pend_q && tick) begin
            state_q <= ACTR_CONV;
            cnt_q   <= first_q ? 5'(`ACTR_FIRST_CYCLES) : 5'(`ACTR_CONV_CYCLES);
            first_q <= 1'b0;
          end
        end
        ACTR_CONV: begin
          if (tick) begin
            cnt_q <= cnt_q - 5'h01;
            if (cnt_q == 5'h01) begin
              state_q <= ACTR_DONE;
            end
          end
        end
        ACTR_DONE: state_q <= ACTR_IDLE;
        default:   state_q <= ACTR_IDLE;
      endcase
    end
  end

  // result capture, blocked while the byte pair is locked
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      result_q <= '0;
    end else if (conv_end && !lock_q) begin
      result_q <= ANA_RESULT;
    end
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      lock_q <= 1'b0;
    end else if (rd_hi) begin
      lock_q <= 1'b0;
    end else if (rd_lo) begin
      lock_q <= 1'b1;
    end
  end

  // done flag, set wins over clear
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      done_q <= 1'b0;
    end else if (conv_end) begin
      done_q <= 1'b1;
    end else if (IRQ_ACK || (wr_ctrl && BUS.wdata[`ACTR_CTRL_DONE])) begin
      done_q <= 1'b0;
    end
  end

  // control registers
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      ctrl_q <= `ACTR_RST_BYTE;
    end else if (wr_ctrl) begin
      ctrl_q <= BUS.wdata & ~(8'h01 << `ACTR_CTRL_START) & ~(8'h01 << `ACTR_CTRL_DONE);
    end
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      trig_q <= `ACTR_RST_BYTE;
    end else if (wr_trig) begin
      trig_q <= BUS.wdata & `ACTR_TRIG_MASK;
    end
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      mux_q <= `ACTR_RST_BYTE;
    end else if (wr_mux) begin
      mux_q <= BUS.wdata & `ACTR_MUX_MASK;
    end
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      buf_q <= `ACTR_RST_BYTE;
    end else if (wr_buf) begin
      buf_q <= BUS.wdata & `ACTR_BUF_MASK;
    end
  end

  // alignment is applied on read, so a change shows at once
  assign rd_low  = left_on ? {result_q[1:0], 6'h00} : result_q[7:0];
  assign rd_high = left_on ? result_q[9:2] : {6'h00, result_q[9:8]};

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      RDATA <= 8'h00;
    end else if (BUS.rd) begin
      case (BUS.addr)
        `ACTR_OFS_RES_LOW:  RDATA <= rd_low;
        `ACTR_OFS_RES_HIGH: RDATA <= rd_high;
        `ACTR_OFS_CTRL:     RDATA <= ctrl_q | {1'b0, state_q != ACTR_IDLE || start_pend_q, 1'b0, done_q, 4'h0};
        `ACTR_OFS_TRIG:     RDATA <= trig_q;
        `ACTR_OFS_MUXCFG:   RDATA <= mux_q;
        `ACTR_OFS_BUFOFF:   RDATA <= buf_q;
        default:            RDATA <= 8'h00;
      endcase
    end else begin
      RDATA <= 8'h00;
    end
  end

  // pin inputs: three stages, accept when second and third agree
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      pin_s1_q     <= 6'h00;
      pin_s2_q     <= 6'h00;
      pin_s3_q     <= 6'h00;
      pin_stable_q <= 6'h00;
    end else begin
      pin_s1_q <= PIN_IN;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      for (int i = 0; i < 6; i++) begin
        if (pin_s2_q[i] == pin_s3_q[i]) begin
          pin_stable_q[i] <= pin_s3_q[i];
        end
      end
    end
  end

  // outputs
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      PIN_SEEN       <= 6'h00;
      PIN_BUF_OFF    <= 6'h00;
      CONV_CLK_EN    <= 1'b0;
      CONV_BUSY      <= 1'b0;
      SAMPLE_REQ     <= 1'b0;
      CHANNEL_SELECT <= 4'h0;
      DONE_IRQ       <= 1'b0;
    end else begin
      PIN_SEEN       <= pin_stable_q & ~buf_q[5:0];
      PIN_BUF_OFF    <= buf_q[5:0];
      CONV_CLK_EN    <= conv_on && tick;
      CONV_BUSY      <= state_q == ACTR_CONV;
      SAMPLE_REQ     <= conv_end;
      CHANNEL_SELECT <= mux_q[3:0];
      DONE_IRQ       <= done_q && ctrl_q[`ACTR_CTRL_IEN];
    end
  end

  // checks
  lock_hold_a: assert property (@(posedge CLK) disable iff (!NRST)
    lock_q && !rd_hi |=> $stable(result_q)) else $error("result changed while locked");
  lock_set_a: assert property (@(posedge CLK) disable iff (!NRST)
    rd_lo |=> lock_q) else $error("low read did not lock");
  lock_free_a: assert property (@(posedge CLK) disable iff (!NRST)
    rd_hi |=> !lock_q) else $error("high read did not unlock");
  capture_a: assert property (@(posedge CLK) disable iff (!NRST)
    conv_end && !lock_q |=> result_q == $past(ANA_RESULT)) else $error("result not captured");
  sample_out_a: assert property (@(posedge CLK) disable iff (!NRST)
    conv_end |=> SAMPLE_REQ) else $error("conversion end not shown");
  done_set_a: assert property (@(posedge CLK) disable iff (!NRST)
    conv_end |=> done_q) else $error("done flag not set");
  done_clear_a: assert property (@(posedge CLK) disable iff (!NRST)
    IRQ_ACK && !conv_end |=> !done_q) else $error("acknowledge did not clear done");
  free_no_trig_a: assert property (@(posedge CLK) disable iff (!NRST)
    wr_trig && BUS.wdata[2:0] == 3'h0 |=> !trig_edge || !done_q || $rose(done_q)) else $error("free select trigger");
  free_rise_a: assert property (@(posedge CLK) disable iff (!NRST)
    auto_on && src == ACTR_TRG_FREE && !$past(wr_trig) && $rose(done_q) |-> trig_edge)
    else $error("free running did not retrigger");
  trig_start_a: assert property (@(posedge CLK) disable iff (!NRST)
    trig_edge && conv_on_d && state_q != ACTR_CONV |=> start_pend_q) else $error("trigger edge lost");
  auto_off_a: assert property (@(posedge CLK) disable iff (!NRST)
    !auto_on |-> !trig_edge) else $error("trigger without auto mode");
  left_fmt_a: assert property (@(posedge CLK) disable iff (!NRST)
    BUS.rd && BUS.addr == `ACTR_OFS_RES_HIGH && left_on |=> RDATA == $past(result_q[9:2]))
    else $error("left high byte");
  left_zero_a: assert property (@(posedge CLK) disable iff (!NRST)
    BUS.rd && BUS.addr == `ACTR_OFS_RES_LOW && left_on |=> RDATA[5:0] == 6'h00) else $error("left low byte zero");
  right_fmt_a: assert property (@(posedge CLK) disable iff (!NRST)
    BUS.rd && BUS.addr == `ACTR_OFS_RES_LOW && !left_on |=> RDATA == $past(result_q[7:0]))
    else $error("right low byte");
  right_zero_a: assert property (@(posedge CLK) disable iff (!NRST)
    BUS.rd && BUS.addr == `ACTR_OFS_RES_HIGH && !left_on |=> RDATA[7:2] == 6'h00) else $error("right high byte zero");
  rd_quiet_a: assert property (@(posedge CLK) disable iff (!NRST)
    !BUS.rd |=> RDATA == 8'h00) else $error("read data without read");
  pin_mask_a: assert property (@(posedge CLK) disable iff (!NRST)
    buf_q[0] && $past(buf_q[0]) |-> !PIN_SEEN[0]) else $error("disabled pin reads one");
  buf_out_a: assert property (@(posedge CLK) disable iff (!NRST)
    1'b1 |=> {2'b00, PIN_BUF_OFF} == $past(buf_q)) else $error("buffer disable output wrong");
  div_two_a: assert property (@(posedge CLK) disable iff (!NRST)
    conv_on && ctrl_q[2:1] == 2'h0 && tick && !wr_ctrl ##1 !wr_ctrl |-> !tick ##1 tick)
    else $error("divide by two broken");
endmodule // actr_top

// ==== bench/actr_peer.sv ====
// far side model: peripheral flags, analog value and pin levels
`timescale 1ns/1ns
module actr_peer (
  input  wire logic             CLK,
  output actr_pkg::actr_flags_t FLAGS,
  output logic [9:0]            ANA_RESULT,
  output logic [5:0]            PIN_IN
);
  import actr_pkg::*;
  initial begin
    FLAGS = '0;
    ANA_RESULT = 10'h000;
    PIN_IN = 6'h3f;
  end
  // flags are held as levels until the next call
  task automatic put(input logic [6:0] f, input logic [9:0] a);
    @(posedge CLK);
    FLAGS <= f;
    ANA_RESULT <= a;
  endtask
  // pin levels, held until the next call
  task automatic pins(input logic [5:0] p);
    @(posedge CLK);
    PIN_IN <= p;
  endtask
endmodule // actr_peer

// ==== bench/tb_actr_top.sv ====
// testbench for the converter control block
`timescale 1ns/1ns
`include "actr_consts.svh"
module tb_actr_top;
  import actr_pkg::*;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        irq_ack = 1'b0;
  actr_bus_t   bus = '0;
  actr_flags_t flags;
  logic [7:0]  rdata;
  logic [9:0]  ana;
  logic [5:0]  pin_in, pin_seen, buf_off;
  logic        clk_en, busy, smp, done_irq;
  logic [3:0]  chan;
  logic [7:0]  divs [8] = '{8'h02, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80};
  int          bad_count = 0;
  int          total_checks = 0;
  int          cyc = 0;
  int          n;
  always #5 clk = ~clk;
  actr_top uut (.CLK(clk), .NRST(nrst), .BUS(bus), .RDATA(rdata), .FLAGS(flags), .IRQ_ACK(irq_ack),
    .ANA_RESULT(ana), .PIN_IN(pin_in), .PIN_SEEN(pin_seen), .PIN_BUF_OFF(buf_off), .CONV_CLK_EN(clk_en),
    .CONV_BUSY(busy), .SAMPLE_REQ(smp), .CHANNEL_SELECT(chan), .DONE_IRQ(done_irq));
  actr_peer peer (.CLK(clk), .FLAGS(flags), .ANA_RESULT(ana), .PIN_IN(pin_in));
  task automatic summarize();
    if (bad_count == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  // waits up to lim cycles for a conversion end, compares with want
  task automatic expc(input bit want, input int lim);
    bit hit;
    hit = 1'b0;
    for (int i = 0; i < lim && !hit; i++) begin
      @(posedge clk) #1;
      if (smp === 1'b1) hit = 1'b1;
    end
    chk({7'h00, hit}, {7'h00, want});
  endtask
  task automatic period(output int p);
    p = 0;
    for (int i = 0; i < 300 && clk_en !== 1'b1; i++) @(posedge clk) #1;
    do begin
      @(posedge clk) #1;
      p++;
    end while (clk_en !== 1'b1 && p < 300);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      summarize();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rd(`ACTR_OFS_RES_LOW, `ACTR_RST_BYTE);
    rd(`ACTR_OFS_RES_HIGH, `ACTR_RST_BYTE);
    rd(8'h7d, 8'h00);
    foreach (divs[i]) begin
      wr(`ACTR_OFS_CTRL, 8'h80 | 8'(i));
      period(n);
      period(n);
      chk(n[7:0], divs[i]);
    end
    peer.put(7'h00, 10'h2a5);
    wr(`ACTR_OFS_CTRL, 8'hd8);
    repeat (4) @(posedge clk);
    #1 chk({7'h00, busy}, 8'h01);
    expc(1'b1, 300);
    rd(`ACTR_OFS_CTRL, 8'h98);
    chk({6'h00, busy, done_irq}, 8'h01);
    rd(`ACTR_OFS_RES_LOW, 8'ha5);
    peer.put(7'h00, 10'h15a);
    wr(`ACTR_OFS_CTRL, 8'hd0);
    expc(1'b1, 300);
    rd(`ACTR_OFS_RES_HIGH, 8'h02);
    rd(`ACTR_OFS_RES_LOW, 8'ha5);
    rd(`ACTR_OFS_RES_HIGH, 8'h02);
    wr(`ACTR_OFS_CTRL, 8'hd0);
    expc(1'b1, 300);
    @(posedge clk) irq_ack <= 1'b1;
    @(posedge clk) irq_ack <= 1'b0;
    rd(`ACTR_OFS_CTRL, 8'h80);
    rd(`ACTR_OFS_RES_LOW, 8'h5a);
    rd(`ACTR_OFS_RES_HIGH, 8'h01);
    wr(`ACTR_OFS_MUXCFG, 8'h25);
    rd(`ACTR_OFS_RES_LOW, 8'h80);
    rd(`ACTR_OFS_RES_HIGH, 8'h56);
    chk({4'h0, chan}, 8'h05);
    wr(`ACTR_OFS_TRIG, 8'h00);
    wr(`ACTR_OFS_CTRL, 8'he0);
    expc(1'b1, 300);
    expc(1'b1, 300);
    wr(`ACTR_OFS_TRIG, 8'h01);
    wr(`ACTR_OFS_TRIG, 8'h00);
    expc(1'b0, 300);
    peer.put(7'h02, 10'h0ff);
    wr(`ACTR_OFS_TRIG, 8'h01);
    wr(`ACTR_OFS_TRIG, 8'h02);
    expc(1'b1, 300);
    for (int c = 1; c < 8; c++) begin
      peer.put(7'h00, 10'h0ff);
      wr(`ACTR_OFS_CTRL, 8'hb0);
      wr(`ACTR_OFS_TRIG, 8'(c));
      peer.put(7'h01 << (c - 1), 10'h0ff);
      expc(1'b1, 300);
      expc(1'b0, 100);
    end
    rd(`ACTR_OFS_TRIG, 8'h07);
    wr(`ACTR_OFS_CTRL, 8'h90);
    peer.put(7'h00, 10'h0ff);
    wr(`ACTR_OFS_TRIG, 8'h01);
    peer.put(7'h01, 10'h0ff);
    expc(1'b0, 200);
    wr(`ACTR_OFS_BUFOFF, 8'h15);
    rd(`ACTR_OFS_BUFOFF, 8'h15);
    repeat (6) @(posedge clk);
    #1 chk({2'b00, pin_seen}, 8'h2a);
    chk({2'b00, buf_off}, 8'h15);
    peer.pins(6'h0b);
    repeat (6) @(posedge clk);
    #1 chk({2'b00, pin_seen}, 8'h0a);
    summarize();
  end
endmodule // tb_actr_top
